// >>> hw/fpci_defs.svh
// Constants for the flash page command interface
`ifndef FPCI_DEFS_SVH
`define FPCI_DEFS_SVH

// ---------------------------------------------------------------
// Register selects
// ---------------------------------------------------------------
`define FPCI_SEL_COMMAND 3'h0
`define FPCI_SEL_DATA_ONE 3'h1
`define FPCI_SEL_DATA_TWO 3'h2
`define FPCI_SEL_DATA_THREE 3'h3
`define FPCI_SEL_DATA_FOUR 3'h4
`define FPCI_SEL_ADDR_HIGH 3'h5
`define FPCI_SEL_ADDR_LOW 3'h6

// ---------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------
`define FPCI_CMD_READ_PAGE 8'h01
`define FPCI_CMD_WRITE_PAGE 8'h02
`define FPCI_CMD_RESERVED 8'h03
`define FPCI_CMD_VERIFY 8'h04
`define FPCI_CMD_ERASE_PAGE 8'h05
`define FPCI_CMD_ERASE_ALL 8'h06
`define FPCI_CMD_READ_BYTE 8'h81
`define FPCI_CMD_WRITE_BYTE 8'h82
`define FPCI_CMD_NORMAL 8'h0f
`define FPCI_CMD_LOAD 8'hf0

// ---------------------------------------------------------------
// Array limits and reset values
// ---------------------------------------------------------------
`define FPCI_DATA_PAGES 1024
`define FPCI_DATA_PAGE_LIMIT 16'h0400
`define FPCI_DATA_BYTE_LIMIT 16'h0fff
`define FPCI_PROG_PAGE_LIMIT 8'he0
`define FPCI_PROG_BYTE_LIMIT 16'hdfff
`define FPCI_PROG_ROW_BYTES 256
`define FPCI_PROG_ERASE_MASK 16'hffc0
`define FPCI_ERASED 8'hff
`define FPCI_REG_RESET 8'h00
`define FPCI_VERIFY_FAIL 8'h01

`endif

// >>> hw/fpci_pkg.sv
// Types for the flash page command interface
`default_nettype none
package fpci_pkg;
  typedef enum logic [2:0] {
    FPCI_IDLE, FPCI_PAGE, FPCI_ROW, FPCI_WIPE, FPCI_FINISH
  } fpci_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] sel;
    logic [7:0] wdata;
  } fpci_sfr_req_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fpci_mem_req_t;
endpackage
`default_nettype wire

// >>> hw/fpci_flash_if.sv
// Flash command engine with data flash array and program flash port
`include "fpci_defs.svh"
`default_nettype none
module fpci_flash_if #(
  parameter int DATA_PAGES = `FPCI_DATA_PAGES,
  parameter int PROG_WORDS = 57344
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Special function register access from the core
  input wire fpci_pkg::fpci_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic core_hold,
  // Program flash port
  output fpci_pkg::fpci_mem_req_t prog_req,
  input wire logic [7:0] prog_rdata,
  // Auxiliary RAM read port
  output logic aux_req,
  output logic [7:0] aux_addr,
  input wire logic [7:0] aux_rdata,
  // Mode indication
  output logic program_load_mode
);
  import fpci_pkg::*;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] data_mem [0:DATA_PAGES*4-1];
  logic [7:0] data_reg [0:3];
  logic [7:0] addr_high, addr_low, command;
  logic [7:0] next_data_reg [0:3];
  logic [7:0] next_addr_high, next_addr_low, next_command;
  logic next_program_load_mode, next_core_hold, next_aux_req;
  logic [7:0] next_sfr_rdata, next_aux_addr;
  fpci_state_t state, next_state;
  logic [15:0] count, next_count;
  fpci_mem_req_t next_prog_req;
  logic mem_we;
  logic [11:0] mem_addr;
  logic [7:0] mem_wdata;
  logic wipe_all;

  wire logic [15:0] byte_addr = {addr_high, addr_low};
  wire logic [11:0] page_base = {byte_addr[9:0], 2'b00};

  function automatic logic [7:0] sfr_read(input logic [2:0] s, input logic [7:0] c,
                                          input logic [7:0] h, input logic [7:0] l,
                                          input logic [7:0] d0, input logic [7:0] d1,
                                          input logic [7:0] d2, input logic [7:0] d3);
    unique case (s)
      `FPCI_SEL_COMMAND: sfr_read = c;
      `FPCI_SEL_DATA_ONE: sfr_read = d0;
      `FPCI_SEL_DATA_TWO: sfr_read = d1;
      `FPCI_SEL_DATA_THREE: sfr_read = d2;
      `FPCI_SEL_DATA_FOUR: sfr_read = d3;
      `FPCI_SEL_ADDR_HIGH: sfr_read = h;
      `FPCI_SEL_ADDR_LOW: sfr_read = l;
      default: sfr_read = `FPCI_REG_RESET;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Command engine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_count = count;
    next_command = command;
    next_addr_high = addr_high;
    next_addr_low = addr_low;
    for (int i = 0; i < 4; i++) begin
      next_data_reg[i] = data_reg[i];
    end
    next_program_load_mode = program_load_mode;
    next_core_hold = core_hold;
    next_sfr_rdata = sfr_rdata;
    next_prog_req = '0;
    next_aux_req = 1'b0;
    next_aux_addr = aux_addr;
    mem_we = 1'b0;
    mem_addr = page_base;
    mem_wdata = `FPCI_ERASED;
    wipe_all = 1'b0;
    unique case (state)
      FPCI_IDLE: begin
        if (sfr_req.rd) begin
          next_sfr_rdata = sfr_read(sfr_req.sel, command, addr_high, addr_low,
                                    data_reg[0], data_reg[1], data_reg[2], data_reg[3]);
        end
        if (sfr_req.wr) begin
          unique case (sfr_req.sel)
            `FPCI_SEL_DATA_ONE: next_data_reg[0] = sfr_req.wdata;
            `FPCI_SEL_DATA_TWO: next_data_reg[1] = sfr_req.wdata;
            `FPCI_SEL_DATA_THREE: next_data_reg[2] = sfr_req.wdata;
            `FPCI_SEL_DATA_FOUR: next_data_reg[3] = sfr_req.wdata;
            `FPCI_SEL_ADDR_HIGH: next_addr_high = sfr_req.wdata;
            `FPCI_SEL_ADDR_LOW: next_addr_low = sfr_req.wdata;
            `FPCI_SEL_COMMAND: begin
              next_command = sfr_req.wdata;
              next_state = FPCI_FINISH;
              next_core_hold = 1'b1;
              unique case (sfr_req.wdata)
                `FPCI_CMD_READ_PAGE: begin
                  if (!program_load_mode) begin
                    for (int i = 0; i < 4; i++) begin
                      next_data_reg[i] = data_mem[page_base + 12'(i)];
                    end
                  end
                end
                `FPCI_CMD_WRITE_PAGE: begin
                  if (program_load_mode && addr_high < `FPCI_PROG_PAGE_LIMIT) begin
                    next_state = FPCI_ROW;
                    next_count = '0;
                    next_aux_req = 1'b1;
                    next_aux_addr = 8'h00;
                  end else if (!program_load_mode &&
                               byte_addr < `FPCI_DATA_PAGE_LIMIT) begin
                    next_state = FPCI_PAGE;
                    next_count = '0;
                  end
                end
                `FPCI_CMD_VERIFY: begin
                  if (!program_load_mode) begin
                    next_command = `FPCI_REG_RESET;
                    for (int i = 0; i < 4; i++) begin
                      if (data_mem[page_base + 12'(i)] != data_reg[i]) begin
                        next_command = `FPCI_VERIFY_FAIL;
                      end
                    end
                  end
                end
                `FPCI_CMD_ERASE_PAGE: begin
                  next_state = program_load_mode ? FPCI_WIPE : FPCI_PAGE;
                  next_count = program_load_mode ? (byte_addr & `FPCI_PROG_ERASE_MASK)
                                                 : 16'h0004;
                end
                `FPCI_CMD_ERASE_ALL: begin
                  if (program_load_mode) begin
                    next_state = FPCI_WIPE;
                    next_count = '0;
                  end else begin
                    wipe_all = 1'b1;
                  end
                end
                `FPCI_CMD_READ_BYTE: begin
                  if (!program_load_mode && byte_addr <= `FPCI_DATA_BYTE_LIMIT) begin
                    next_data_reg[0] = data_mem[byte_addr[11:0]];
                  end
                end
                `FPCI_CMD_WRITE_BYTE: begin
                  if (program_load_mode) begin
                    if (byte_addr <= `FPCI_PROG_BYTE_LIMIT) begin
                      next_prog_req = '{req: 1'b1, we: 1'b1, addr: byte_addr,
                                        wdata: data_reg[0]};
                    end
                  end else if (byte_addr <= `FPCI_DATA_BYTE_LIMIT) begin
                    mem_we = 1'b1;
                    mem_addr = byte_addr[11:0];
                    mem_wdata = data_reg[0];
                  end
                end
                `FPCI_CMD_NORMAL: next_program_load_mode = 1'b0;
                `FPCI_CMD_LOAD: next_program_load_mode = 1'b1;
                `FPCI_CMD_RESERVED: next_state = FPCI_FINISH;
                default: next_state = FPCI_FINISH;
              endcase
            end
            default: ;
          endcase
        end
      end
      FPCI_PAGE: begin
        // Program data registers, or erase when count starts at four
        mem_we = 1'b1;
        mem_addr = page_base + 12'(count[1:0]);
        mem_wdata = count[2] ? `FPCI_ERASED : data_reg[count[1:0]];
        next_count = count + 16'h0001;
        if (count[1:0] == 2'b11) begin
          next_state = FPCI_FINISH;
        end
      end
      FPCI_ROW: begin
        // Auxiliary RAM data arrives in the same cycle as its address
        next_prog_req = '{req: 1'b1, we: 1'b1, addr: {addr_high, count[7:0]},
                          wdata: aux_rdata};
        next_count = count + 16'h0001;
        next_aux_addr = aux_addr + 8'h01;
        next_aux_req = count < 16'(`FPCI_PROG_ROW_BYTES - 1);
        if (count == 16'(`FPCI_PROG_ROW_BYTES - 1)) begin
          next_state = FPCI_FINISH;
        end
      end
      FPCI_WIPE: begin
        next_prog_req = '{req: 1'b1, we: 1'b1, addr: count, wdata: `FPCI_ERASED};
        next_count = count + 16'h0001;
        if ((command == `FPCI_CMD_ERASE_PAGE && count[5:0] == 6'h3f) ||
            count == 16'(PROG_WORDS - 1)) begin
          next_state = FPCI_FINISH;
        end
      end
      FPCI_FINISH: begin
        next_state = FPCI_IDLE;
        next_core_hold = 1'b0;
      end
      default: next_state = FPCI_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= FPCI_IDLE;
      count <= '0;
      command <= `FPCI_REG_RESET;
      addr_high <= `FPCI_REG_RESET;
      addr_low <= `FPCI_REG_RESET;
      for (int i = 0; i < 4; i++) begin
        data_reg[i] <= `FPCI_REG_RESET;
      end
      program_load_mode <= 1'b0;
      core_hold <= 1'b0;
      sfr_rdata <= `FPCI_REG_RESET;
      prog_req <= '0;
      aux_req <= 1'b0;
      aux_addr <= 8'h00;
    end else begin
      state <= next_state;
      count <= next_count;
      command <= next_command;
      addr_high <= next_addr_high;
      addr_low <= next_addr_low;
      for (int i = 0; i < 4; i++) begin
        data_reg[i] <= next_data_reg[i];
      end
      program_load_mode <= next_program_load_mode;
      core_hold <= next_core_hold;
      sfr_rdata <= next_sfr_rdata;
      prog_req <= next_prog_req;
      aux_req <= next_aux_req;
      aux_addr <= next_aux_addr;
    end
  end

  // ---------------------------------------------------------------
  // Data flash array
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (wipe_all) begin
      for (int i = 0; i < DATA_PAGES * 4; i++) begin
        data_mem[i] <= `FPCI_ERASED;
      end
    end else if (mem_we) begin
      data_mem[mem_addr] <= mem_wdata;
    end
  end
endmodule
`default_nettype wire

// >>> tb/fpci_flash_if_assertions.sv
// Assertion checker for the flash page command interface
`include "fpci_defs.svh"
`default_nettype none
module fpci_flash_if_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Watched ports
  input wire fpci_pkg::fpci_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic core_hold,
  input wire fpci_pkg::fpci_mem_req_t prog_req,
  input wire logic aux_req,
  input wire logic program_load_mode
);
  import fpci_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // ----------------
  // Command steps
  // ----------------
  sequence cmd_s(logic [7:0] code);
    sfr_req.wr && sfr_req.sel == `FPCI_SEL_COMMAND && sfr_req.wdata == code && !core_hold;
  endsequence
  sequence quiet_s;
    (!prog_req.req && !aux_req) [*3];
  endsequence
  a_reset_normal_mode: assert property ($fell(srst) |-> !program_load_mode && !core_hold)
    else $error("mode or hold set after reset");
  a_cmd_raises_hold: assert property (sfr_req.wr && sfr_req.sel == 3'h0 && !core_hold
    |=> core_hold)
    else $error("command did not hold the core");
  a_load_mode_enter: assert property (cmd_s(`FPCI_CMD_LOAD) |-> ##[1:3] program_load_mode)
    else $error("load mode not entered");
  a_normal_mode_enter: assert property (cmd_s(`FPCI_CMD_NORMAL)
    |-> ##[1:3] !program_load_mode)
    else $error("normal mode not entered");
  a_reserved_runs_nothing: assert property (cmd_s(`FPCI_CMD_RESERVED)
    |=> quiet_s ##0 !core_hold)
    else $error("reserved code started work");
  a_unknown_keeps_mode: assert property (cmd_s(8'h77) |=> $stable(program_load_mode) [*3])
    else $error("unknown code changed mode");
  a_prog_in_load: assert property (prog_req.req |-> program_load_mode && core_hold)
    else $error("program write outside load operation");
  a_aux_in_load: assert property (aux_req |-> program_load_mode && core_hold)
    else $error("auxiliary read outside load write");
  a_rdata_holds: assert property (!$past(sfr_req.rd) && !$past(srst) |-> $stable(sfr_rdata))
    else $error("read data changed without a read");
endmodule
`default_nettype wire

// >>> tb/fpci_far_side.sv
// Model of the auxiliary RAM and program flash beyond the interface
`default_nettype none
module fpci_far_side (
  // Clock and log clear
  input wire logic clk_sys,
  input wire logic clr,
  // Auxiliary RAM read port
  input wire logic aux_req,
  input wire logic [7:0] aux_addr,
  output logic [7:0] aux_rdata,
  // Program flash port and write log
  input wire fpci_pkg::fpci_mem_req_t prog_req,
  output logic [7:0] prog_rdata,
  output logic [15:0] n_pulse,
  output logic [15:0] first_addr,
  output logic [15:0] last_addr,
  output logic [7:0] last_data
);
  import fpci_pkg::*;
  // Data is a pattern of the address; inverse when not asked
  // Read is combinational: the interface takes the byte at the edge after its address
  always_comb begin
    aux_rdata = aux_req ? (aux_addr ^ 8'h5a) : ~(aux_addr ^ 8'h5a);
    prog_rdata = ~prog_req.wdata;
  end
  always @(posedge clk_sys) begin
    if (clr) begin
      n_pulse <= 16'h0000;
    end else if (prog_req.req && prog_req.we) begin
      if (n_pulse == 16'h0000) begin
        first_addr <= prog_req.addr;
      end
      n_pulse <= n_pulse + 16'h0001;
      last_addr <= prog_req.addr;
      last_data <= prog_req.wdata;
    end
  end
endmodule
`default_nettype wire

// >>> tb/fpci_flash_if_tb_top.sv
// Testbench for the flash page command interface
`include "fpci_defs.svh"
`default_nettype none
module fpci_flash_if_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fpci_pkg::*;
  logic clk_sys, srst, clr, core_hold, aux_req, program_load_mode;
  fpci_sfr_req_t sfr_req;
  fpci_mem_req_t prog_req;
  logic [7:0] sfr_rdata, prog_rdata, aux_addr, aux_rdata, last_data;
  logic [15:0] n_pulse, first_addr, last_addr;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  fpci_flash_if #(.PROG_WORDS(128)) dut (.clk_sys(clk_sys), .srst(srst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .core_hold(core_hold), .prog_req(prog_req), .prog_rdata(prog_rdata),
    .aux_req(aux_req), .aux_addr(aux_addr), .aux_rdata(aux_rdata),
    .program_load_mode(program_load_mode));
  fpci_far_side far (.clk_sys(clk_sys), .clr(clr), .aux_req(aux_req), .aux_addr(aux_addr),
    .aux_rdata(aux_rdata), .prog_req(prog_req), .prog_rdata(prog_rdata), .n_pulse(n_pulse),
    .first_addr(first_addr), .last_addr(last_addr), .last_data(last_data));
  // ----------------
  // Access tasks
  // ----------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_req <= {1'b1, 1'b0, sel, d};
    @(posedge clk_sys);
    sfr_req <= '0;
  endtask
  task automatic rd(input logic [2:0] sel, output logic [7:0] d);
    @(posedge clk_sys);
    sfr_req <= {1'b0, 1'b1, sel, 8'h00};
    @(posedge clk_sys);
    sfr_req <= '0;
    @(posedge clk_sys);
    d = sfr_rdata;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    @(posedge clk_sys);
    while (core_hold === 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 400) begin
      n_mismatch++;
      $display("MISMATCH %0t core_hold stuck high", $time);
    end
  endtask
  task automatic cmd(input logic [7:0] code);
    clr <= 1'b1;
    wr(`FPCI_SEL_COMMAND, code);
    clr <= 1'b0;
    wait_idle();
  endtask
  task automatic addr(input logic [7:0] h, input logic [7:0] l);
    wr(`FPCI_SEL_ADDR_HIGH, h);
    wr(`FPCI_SEL_ADDR_LOW, l);
  endtask
  task automatic page_set(input logic [31:0] v);
    for (int i = 0; i < 4; i++) wr(3'(i + 1), v[31 - 8 * i -: 8]);
  endtask
  task automatic page_chk(input logic [31:0] v);
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      rd(3'(i + 1), d);
      chk({8'h00, d}, {8'h00, v[31 - 8 * i -: 8]});
    end
  endtask
  task automatic log_chk(input logic [15:0] n, input logic [15:0] a0, input logic [15:0] a1);
    chk(n_pulse, n);
    chk(first_addr, a0);
    chk(last_addr, a1);
  endtask
  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ----------------
  // Scenarios
  // ----------------
  initial begin
    logic [7:0] d;
    logic [7:0] odd [2];
    odd = '{8'h03, 8'h77};
    sfr_req = '0;
    srst = 1'b1;
    clr = 1'b0;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    for (int s = 0; s < 8; s++) begin
      rd(3'(s), d);
      chk({8'h00, d}, 16'h0000);
    end
    chk({15'h0, program_load_mode}, 16'h0000);
    cmd(`FPCI_CMD_ERASE_ALL);
    addr(8'h00, 8'h03);
    cmd(`FPCI_CMD_READ_PAGE);
    page_chk(32'hffffffff);
    page_set(32'h11223344);
    cmd(`FPCI_CMD_WRITE_PAGE);
    page_set(32'h00000000);
    cmd(`FPCI_CMD_READ_PAGE);
    page_chk(32'h11223344);
    cmd(`FPCI_CMD_VERIFY);
    rd(`FPCI_SEL_COMMAND, d);
    chk({8'h00, d}, 16'h0000);
    wr(`FPCI_SEL_DATA_FOUR, 8'h45);
    cmd(`FPCI_CMD_VERIFY);
    rd(`FPCI_SEL_COMMAND, d);
    chk({8'h00, d}, {8'h00, `FPCI_VERIFY_FAIL});
    addr(8'h00, 8'h0e);
    cmd(`FPCI_CMD_READ_BYTE);
    rd(`FPCI_SEL_DATA_ONE, d);
    chk({8'h00, d}, 16'h0033);
    addr(8'h00, 8'h10);
    wr(`FPCI_SEL_DATA_ONE, 8'h5a);
    cmd(`FPCI_CMD_WRITE_BYTE);
    addr(8'h00, 8'h04);
    cmd(`FPCI_CMD_READ_PAGE);
    page_chk(32'h5affffff);
    addr(8'h00, 8'h03);
    cmd(`FPCI_CMD_ERASE_PAGE);
    cmd(`FPCI_CMD_READ_PAGE);
    page_chk(32'hffffffff);
    page_set(32'ha1b2c3d4);
    for (int k = 0; k < 2; k++) begin
      cmd(odd[k]);
      rd(`FPCI_SEL_COMMAND, d);
      chk({8'h00, d}, {8'h00, odd[k]});
      page_chk(32'ha1b2c3d4);
    end
    wr(`FPCI_SEL_COMMAND, `FPCI_CMD_WRITE_PAGE);
    wr(`FPCI_SEL_DATA_ONE, 8'h99);
    wait_idle();
    page_chk(32'ha1b2c3d4);
    cmd(`FPCI_CMD_LOAD);
    cmd(`FPCI_CMD_LOAD);
    chk({15'h0, program_load_mode}, 16'h0001);
    page_set(32'h5e6f7a8b);
    cmd(`FPCI_CMD_READ_PAGE);
    cmd(`FPCI_CMD_READ_BYTE);
    cmd(`FPCI_CMD_VERIFY);
    rd(`FPCI_SEL_COMMAND, d);
    chk({8'h00, d}, {8'h00, `FPCI_CMD_VERIFY});
    page_chk(32'h5e6f7a8b);
    addr(8'h02, 8'h00);
    cmd(`FPCI_CMD_WRITE_PAGE);
    log_chk(16'h0100, 16'h0200, 16'h02ff);
    chk({8'h00, last_data}, 16'h00a5);
    addr(8'h03, 8'h45);
    cmd(`FPCI_CMD_ERASE_PAGE);
    log_chk(16'h0040, 16'h0340, 16'h037f);
    cmd(`FPCI_CMD_ERASE_ALL);
    log_chk(16'h0080, 16'h0000, 16'h007f);
    addr(8'h12, 8'h34);
    wr(`FPCI_SEL_DATA_ONE, 8'hc3);
    cmd(`FPCI_CMD_WRITE_BYTE);
    log_chk(16'h0001, 16'h1234, 16'h1234);
    chk({8'h00, last_data}, 16'h00c3);
    cmd(`FPCI_CMD_NORMAL);
    cmd(`FPCI_CMD_NORMAL);
    chk({15'h0, program_load_mode}, 16'h0000);
    final_report();
  end
endmodule
bind fpci_flash_if fpci_flash_if_assertions chk_i (.clk_sys(clk_sys), .srst(srst),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .core_hold(core_hold), .prog_req(prog_req),
  .aux_req(aux_req), .program_load_mode(program_load_mode));
`default_nettype wire
